// *** hdl/spcr_top.sv ***
// spcr serial peripheral controller: registers, engine, select, fifos
// assumes link pins are asynchronous to mclk and slower than mclk/4
`timescale 1ns/1ns
`include "spcr_map.svh"
// Function
// (RULE1) read-start bit clears itself when the transfer completes; code clears it in master role only
// (RULE2) auto select drives select active in modes 0 and 2, single wire
// (RULE3) wire field: 00 single, 01 dual, 10 single ddr, 11 dual ddr
// (RULE4) size field: 8, 16 or 32 bit words, 11 reserved
// (RULE5) bit order field picks msb first or lsb first both ways
// (RULE6) master select output follows the level bit, reset high
// (RULE7) enables gate tx irq, rx irq, tx dma, rx dma requests
// (RULE8) master clock is bus clock over twice the divider
// (RULE9) slave ignores the divider and follows the incoming clock
// (RULE10) software never writes divider zero while in use
// (RULE11) fifo overflow sets the tx or rx error flag
// (RULE12) writing one to an error flag clears it and empties the fifo
// (RULE13) bus error flag set on error, cleared by writing one
// (RULE14) dma mode: done flag set when all data moved and clock idle
// (RULE15) cpu mode: done flag set after each word, write one clears
// (RULE16) tx and rx pending flags set on request, write one clears
// (RULE17) receive fifo is 32 bits wide, 32 deep
// (RULE18) role bit 0 is master, 1 is slave
// (RULE19) clock mode field sets polarity and phase, reset mode 3
// (RULE20) live fifo empty and full flags, empties read one at reset
// (RULE21) reading receive word pops, writing transmit word pushes
module spcr_top #(
    parameter int FW = `SPCR_FIFO_W,
    parameter int FD = `SPCR_FIFO_D
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [4:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // system events
    input  wire logic        bus_fault,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             tx_drq,
    output logic             rx_drq,
    // serial link
    output logic             serial_clock_out,
    input  wire logic        sclk_in,
    output logic             select_out_n,
    input  wire logic        select_in_n,
    output logic             sdo,
    output logic             sdo_oe_n,
    input  wire logic        sdi
);
    // ----------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------
    logic       rs1_q, rst_n;
    logic [2:0] p1_q, p2_q;
    logic       sclk_prev_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p1_q        <= 3'h6;
            p2_q        <= 3'h6;
            sclk_prev_q <= 1'b1;
        end else begin
            p1_q        <= {sclk_in, select_in_n, sdi};
            p2_q        <= p1_q;
            sclk_prev_q <= p2_q[2];
        end
    end
    wire s_clk = p2_q[2];
    wire s_sel = p2_q[1];
    wire s_din = p2_q[0];

    // ----------------------------------------
    // registers and decode
    // ----------------------------------------
    logic [31:0] ctl_q;
    logic [9:0]  div_q;
    logic        txerr_q, rxerr_q, buserr_q, done_q, txp_q, rxp_q;
    spcr_pkg::spcr_state_t st_q, st_d;
    spcr_fifo_if #(.W(FW)) txf ();
    spcr_fifo_if #(.W(FW)) rxf ();

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction
    wire wr_ctl  = wr & hit(addr, `SPCR_OFF_CTL);
    wire wr_div  = wr & hit(addr, `SPCR_OFF_DIV);
    wire wr_stat = wr & hit(addr, `SPCR_OFF_STAT);
    wire wr_txd  = wr & hit(addr, `SPCR_OFF_TXD);
    wire rd_rxd  = rd & hit(addr, `SPCR_OFF_RXD);

    wire       role_slave = ctl_q[`SPCR_C_ROLE];               // [RULE18]
    wire       cpol       = ctl_q[`SPCR_C_CPOL];               // [RULE19]
    wire       cpha       = ctl_q[`SPCR_C_CPHA];               // [RULE19]
    wire       lsb_first  = ctl_q[`SPCR_C_ORDER];
    wire       rd_start   = ctl_q[`SPCR_C_RDSTART];
    wire       dma_mode   = ctl_q[`SPCR_C_TXDE] | ctl_q[`SPCR_C_RXDE];
    wire spcr_pkg::spcr_wire_t wmode =
        spcr_pkg::spcr_wire_t'(ctl_q[`SPCR_C_WIRE]);
    wire       std_wire   = (wmode == spcr_pkg::SPCR_W1S);     // [RULE3]
    wire       auto_sel   = ctl_q[`SPCR_C_AUTOSEL] & ~cpha & std_wire; // [RULE2]
    wire spcr_pkg::spcr_size_t sz =
        spcr_pkg::spcr_size_t'(ctl_q[`SPCR_C_SIZE]);
    // reserved size falls back to 32 bits rather than stalling the engine
    wire [5:0] nbits = (sz == spcr_pkg::SPCR_SZ8)  ? `SPCR_BITS8 :
                       (sz == spcr_pkg::SPCR_SZ16) ? `SPCR_BITS16 :
                       `SPCR_BITS32;                           // [RULE4]

    // ----------------------------------------
    // shift engine
    // ----------------------------------------
    logic [31:0] txw_q, rxw_q;
    logic [5:0]  cnt_q;
    logic [9:0]  dcnt_q;
    logic        half_q, sclk_q, sdo_q;

    function automatic logic [4:0] bidx(input logic [5:0] c,
                                        input logic [5:0] n,
                                        input logic       lsb);
        logic [5:0] i;
        i = lsb ? c : (n - 6'd1 - c);
        return i[4:0];
    endfunction

    // divider zero is a software fault; it then toggles every cycle
    wire [9:0] dlim   = (div_q == 10'h000) ? 10'h000 : div_q - 10'h001; // [RULE10]
    wire       m_tick = (st_q == spcr_pkg::SPCR_RUN) & ~role_slave &
                        (dcnt_q >= dlim);                      // [RULE8]
    wire       s_chg  = (st_q == spcr_pkg::SPCR_RUN) & role_slave &
                        (s_clk ^ sclk_prev_q);                 // [RULE9]
    wire       lead   = role_slave ? (s_chg & (s_clk != cpol))
                                   : (m_tick & ~half_q);
    wire       trail  = role_slave ? (s_chg & (s_clk == cpol))
                                   : (m_tick & half_q);
    wire       smp    = cpha ? trail : lead;
    wire       last   = trail & (cnt_q == nbits - 6'd1);
    wire       m_go   = ~role_slave & (~txf.empty | rd_start);
    wire       s_go   = role_slave & ~s_sel;
    wire       start  = (st_q == spcr_pkg::SPCR_IDLE) & (m_go | s_go);
    wire [31:0] ldw   = txf.empty ? 32'h0000_0000 : txf.rdata;
    wire [5:0] oidx_c = cpha ? cnt_q : cnt_q + 6'd1;

    always_comb begin
        st_d = st_q;
        case (st_q)
            spcr_pkg::SPCR_IDLE: if (start) st_d = spcr_pkg::SPCR_RUN;
            spcr_pkg::SPCR_RUN: begin
                if (last) st_d = spcr_pkg::SPCR_DONE;
                else if (role_slave & s_sel) st_d = spcr_pkg::SPCR_IDLE;
            end
            spcr_pkg::SPCR_DONE: st_d = spcr_pkg::SPCR_IDLE;
            default: st_d = spcr_pkg::SPCR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= spcr_pkg::SPCR_IDLE;
            txw_q  <= 32'h0000_0000;
            rxw_q  <= 32'h0000_0000;
            cnt_q  <= 6'h00;
            dcnt_q <= 10'h000;
            half_q <= 1'b0;
            sclk_q <= 1'b1;
            sdo_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            dcnt_q <= (m_tick | ~(st_q == spcr_pkg::SPCR_RUN)) ? 10'h000
                                                           : dcnt_q + 10'h001;
            if (start) begin
                txw_q  <= ldw;
                cnt_q  <= 6'h00;
                half_q <= 1'b0;
                sdo_q  <= ldw[bidx(6'h00, nbits, lsb_first)];  // [RULE5]
            end else begin
                if (m_tick) half_q <= ~half_q;
                if (smp) rxw_q[bidx(cnt_q, nbits, lsb_first)] <= s_din; // [RULE5]
                if (cpha ? lead : (trail & ~last))
                    sdo_q <= txw_q[bidx(oidx_c, nbits, lsb_first)];
                if (trail) cnt_q <= cnt_q + 6'h01;
            end
            // idle level follows polarity; master toggles on each tick
            if (st_q != spcr_pkg::SPCR_RUN) sclk_q <= cpol;    // [RULE19]
            else if (m_tick) sclk_q <= ~sclk_q;                // [RULE8]
        end
    end
    wire word_done = (st_q == spcr_pkg::SPCR_DONE);
    wire [31:0] rx_word = (sz == spcr_pkg::SPCR_SZ8)  ? {24'h0, rxw_q[7:0]} :
                          (sz == spcr_pkg::SPCR_SZ16) ? {16'h0, rxw_q[15:0]} :
                          rxw_q;

    // ----------------------------------------
    // fifos
    // ----------------------------------------
    wire tx_ovf = wr_txd & txf.full;                           // [RULE11]
    wire rx_ovf = word_done & rxf.full;                        // [RULE11]
    wire txclr  = wr_stat & wdata[`SPCR_S_TXERR];
    wire rxclr  = wr_stat & wdata[`SPCR_S_RXERR];
    assign txf.push  = wr_txd;                                 // [RULE21]
    assign txf.pdata = wdata;
    assign txf.pop   = start;
    assign txf.flush = txclr;                                  // [RULE12]
    assign rxf.push  = word_done;
    assign rxf.pdata = rx_word;
    assign rxf.pop   = rd_rxd;                                 // [RULE21]
    assign rxf.flush = rxclr;                                  // [RULE12]

    spcr_fifo #(.W(FW), .D(FD), .AW($clog2(FD))) u_txf (
        .clk   (mclk),
        .rst_n (rst_n),
        .f     (txf)
    );
    spcr_fifo #(.W(FW), .D(FD), .AW($clog2(FD))) u_rxf (     // [RULE17]
        .clk   (mclk),
        .rst_n (rst_n),
        .f     (rxf)
    );

    // ----------------------------------------
    // status flags: set beats a same-cycle clear
    // ----------------------------------------
    wire done_set = word_done & (~dma_mode | txf.empty); // [RULE14] [RULE15]
    wire [5:0] fset = {tx_ovf, rx_ovf, bus_fault, done_set,
                       txf.empty, ~rxf.empty};
    wire [5:0] fcur = {txerr_q, rxerr_q, buserr_q, done_q, txp_q, rxp_q};
    wire [5:0] fclr = {6{wr_stat}} & wdata[`SPCR_S_TXERR:`SPCR_S_RXP];
    wire [5:0] fnxt = fset | (fcur & ~fclr);                   // [RULE16]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `SPCR_CTL_RST;
            div_q <= `SPCR_DIV_RST;
            {txerr_q, rxerr_q, buserr_q, done_q, txp_q, rxp_q} <= 6'h00;
        end else begin
            if (wr_ctl) ctl_q <= wdata & `SPCR_CTL_MASK;
            else if (word_done & ~role_slave)
                ctl_q[`SPCR_C_RDSTART] <= 1'b0;                // [RULE1]
            if (wr_div) div_q <= wdata[9:0];
            {txerr_q, rxerr_q, buserr_q, done_q, txp_q, rxp_q} <= fnxt; // [RULE13]
        end
    end

    // ----------------------------------------
    // read port and outputs
    // ----------------------------------------
    wire [31:0] stat_v = {22'h0, txf.empty, rxf.full, txf.full, rxf.empty,
                          fcur};                               // [RULE20]
    wire [31:0] rmux = hit(addr, `SPCR_OFF_CTL)  ? ctl_q :
                       hit(addr, `SPCR_OFF_DIV)  ? {22'h0, div_q} :
                       hit(addr, `SPCR_OFF_STAT) ? stat_v :
                       hit(addr, `SPCR_OFF_RXD)  ? rxf.rdata :
                       32'h0000_0000;
    wire busy   = (st_q != spcr_pkg::SPCR_IDLE);
    wire ss_nxt = role_slave ? 1'b1 :
                  auto_sel   ? ~busy :                         // [RULE2]
                  ctl_q[`SPCR_C_SELLVL];                       // [RULE6]
    wire [3:0] req = {txp_q, rxp_q, ~txf.full, ~rxf.empty} &
                     ctl_q[`SPCR_C_TXIE:`SPCR_C_RXDE];         // [RULE7]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata            <= 32'h0000_0000;
            {tx_irq, rx_irq, tx_drq, rx_drq} <= 4'h0;
            serial_clock_out <= 1'b1;
            select_out_n     <= 1'b1;
            sdo              <= 1'b0;
            sdo_oe_n         <= 1'b1;
        end else begin
            rdata            <= rd ? rmux : 32'h0000_0000;
            {tx_irq, rx_irq, tx_drq, rx_drq} <= req;
            serial_clock_out <= role_slave ? cpol : sclk_q;
            select_out_n     <= ss_nxt;
            sdo              <= sdo_q;
            sdo_oe_n         <= role_slave ? s_sel : 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_start_clear: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
        word_done && !role_slave && !wr_ctl |=> !rd_start)
        else $error("read start not cleared after transfer");
    a_sel_level: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
        !role_slave && !auto_sel |=>
        select_out_n == $past(ctl_q[`SPCR_C_SELLVL]))
        else $error("select output does not follow level bit");
    a_auto_sel: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
        !role_slave && auto_sel && busy |=> !select_out_n)
        else $error("auto select not active during transfer");
    a_clk_idle: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE19]
        st_q == spcr_pkg::SPCR_IDLE && $stable(cpol) && !wr_ctl |=> ##1
        serial_clock_out == $past(cpol, 2))
        else $error("serial clock not at idle polarity");
    a_rx_ovf: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
        rx_ovf |=> rxerr_q) else $error("rx overflow not flagged");
    a_err_flush: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
        txclr && !tx_ovf |=> !txerr_q && txf.empty)
        else $error("tx error clear did not empty fifo");
    a_bus_err: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
        bus_fault |=> buserr_q[*2]) else $error("bus error flag lost");
    a_done_cpu: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
        word_done && !dma_mode |=> done_q)
        else $error("done flag missing after word");
    a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE7]
        !ctl_q[`SPCR_C_TXIE] ##1 !ctl_q[`SPCR_C_TXIE] |-> !tx_irq)
        else $error("tx irq raised while disabled");
    a_div_rate: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
        m_tick && div_q > 10'h001 && !wr_div |=> !m_tick)
        else $error("serial clock faster than divider allows");
endmodule // spcr_top

// *** hdl/spcr_map.svh ***
// spcr register map: offsets, field positions, reset values, counts
// assumes a 5-bit byte address on the register port
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define SPCR_OFF_CTL    5'h00
`define SPCR_OFF_DIV    5'h04
`define SPCR_OFF_STAT   5'h08
`define SPCR_OFF_RXD    5'h0C
`define SPCR_OFF_TXD    5'h10
// ----------------------------------------
// control_config fields
// ----------------------------------------
`define SPCR_C_RDSTART  15
`define SPCR_C_AUTOSEL  14
`define SPCR_C_WIRE     13:12
`define SPCR_C_ROLE     10
`define SPCR_C_SIZE     9:8
`define SPCR_C_CPOL     7
`define SPCR_C_CPHA     6
`define SPCR_C_ORDER    5
`define SPCR_C_SELLVL   4
`define SPCR_C_TXIE     3
`define SPCR_C_RXIE     2
`define SPCR_C_TXDE     1
`define SPCR_C_RXDE     0
`define SPCR_CTL_MASK   32'h0000_F7FF
`define SPCR_CTL_RST    32'h0000_00D0
`define SPCR_DIV_RST    10'h000
// ----------------------------------------
// status_flags fields
// ----------------------------------------
`define SPCR_S_TXE      9
`define SPCR_S_RXF      8
`define SPCR_S_TXF      7
`define SPCR_S_RXE      6
`define SPCR_S_TXERR    5
`define SPCR_S_RXERR    4
`define SPCR_S_BUSERR   3
`define SPCR_S_DONE     2
`define SPCR_S_TXP      1
`define SPCR_S_RXP      0
// ----------------------------------------
// counts
// ----------------------------------------
`define SPCR_BITS8      6'd8
`define SPCR_BITS16     6'd16
`define SPCR_BITS32     6'd32
`define SPCR_FIFO_W     32
`define SPCR_FIFO_D     32
`endif

// *** hdl/spcr_pkg.sv ***
// spcr types: word size, wire mode, engine states
// assumes spcr_map.svh for all numeric positions
package spcr_pkg;
    typedef enum logic [1:0] {
        SPCR_SZ8 = 2'h0, SPCR_SZ16 = 2'h1, SPCR_SZ32 = 2'h2, SPCR_SZRSV = 2'h3
    } spcr_size_t;
    typedef enum logic [1:0] {
        SPCR_W1S = 2'h0, SPCR_W2S = 2'h1, SPCR_W1D = 2'h2, SPCR_W2D = 2'h3
    } spcr_wire_t;
    typedef enum logic [2:0] {
        SPCR_IDLE = 3'h1, SPCR_RUN = 3'h2, SPCR_DONE = 3'h4
    } spcr_state_t;
endpackage

// *** hdl/spcr_fifo_if.sv ***
// spcr fifo carrier between the controller and its fifo instances
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface spcr_fifo_if #(parameter int W = 32);
    logic         push;
    logic [W-1:0] pdata;
    logic         pop;
    logic         flush;
    logic [W-1:0] rdata;
    logic         full;
    logic         empty;
    modport fifo (input push, pdata, pop, flush, output rdata, full, empty);
    modport user (output push, pdata, pop, flush, input rdata, full, empty);
endinterface

// *** hdl/spcr_fifo.sv ***
// spcr word fifo in flip-flops
// pops while empty are ignored; pushes while full are dropped
`timescale 1ns/1ns
module spcr_fifo #(
    parameter int W  = 32,
    parameter int D  = 32,
    parameter int AW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fifo port
    spcr_fifo_if.fifo f
);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           do_push = f.push & ~f.full;
    wire           do_pop  = f.pop & ~f.empty;

    assign f.full  = (cnt_q == (AW+1)'(D));
    assign f.empty = (cnt_q == '0);
    assign f.rdata = mem_q[rp_q];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (f.flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            if (do_pop)  rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) mem_q[wp_q] <= f.pdata;
    end

    a_fifo_flush: assert property (@(posedge clk) disable iff (!rst_n)
        f.flush |=> f.empty) else $error("fifo not empty after flush");
endmodule // spcr_fifo

// *** verification/spcr_peer.sv ***
// spcr link peer: serial device in clock mode 3, msb first, 8-bit reply
// assumes the controller is master and drives select low for a frame
`timescale 1ns/1ns
module spcr_peer #(
    parameter logic [7:0] REPLY = 8'h35
) (
    // link pins
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    output logic             miso,
    // captured bits, newest in bit 0
    output logic      [31:0] got
);
    logic [7:0] sh_q;
    initial begin
        sh_q = REPLY;
        miso = 1'b0;
        got  = 32'h0000_0000;
    end
    // reply rotates, so every frame of 8n bits repeats the byte
    always @(negedge sck) if (!sel_n) begin
        miso <= sh_q[7];
        sh_q <= {sh_q[6:0], sh_q[7]};
    end
    always @(posedge sck) if (!sel_n) got <= {got[30:0], mosi};
    // deselected: no stale level for the controller to latch
    always @(posedge sel_n) miso <= ~miso;
endmodule // spcr_peer

// *** verification/tb_top.sv ***
// spcr bench: register tasks, link transfers against the peer
// assumes spcr_top with default fifo sizes and the mode 3 peer
`timescale 1ns/1ns
`include "spcr_map.svh"
module tb_top;
    logic        mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, got, rv;
    logic        bus_fault = 1'b0, sck_d = 1'b1;
    logic        ssck = 1'b1, ssel_n = 1'b1, slv = 1'b0, sbit = 1'b0;
    logic        tx_irq, rx_irq, tx_drq, rx_drq, sco, sel_n, sdo, pmiso, oe_n;
    int          err_total = 0, samples_checked = 0;
    int          cnt = 0, per = 0, sel_lo = 0, s, i;
    logic [31:0] ctl_t [3] = '{32'h0000_00C4, 32'h0000_00E4, 32'h0000_01C4};
    logic [31:0] tx_t  [3] = '{32'h0000_00A5, 32'h0000_001E, 32'h0001_2345};
    logic [31:0] pe_t  [3] = '{32'h0000_00A5, 32'h0000_0078, 32'h0000_2345};
    logic [31:0] pm_t  [3] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_FFFF};
    logic [31:0] re_t  [3] = '{32'h0000_0035, 32'h0000_00AC, 32'h0000_3535};
    always #20 mclk = ~mclk;
    spcr_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .bus_fault(bus_fault),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_drq(tx_drq), .rx_drq(rx_drq),
        .serial_clock_out(sco), .sclk_in(ssck), .select_out_n(sel_n),
        .select_in_n(ssel_n), .sdo(sdo), .sdo_oe_n(oe_n),
        .sdi(slv ? sbit : pmiso));
    spcr_peer peer (.sck(sco), .sel_n(sel_n), .mosi(sdo), .miso(pmiso),
        .got(got));
    // ----------------------------------------
    // link monitor: clock period, select activity
    // ----------------------------------------
    always @(posedge mclk) begin
        sck_d <= sco;
        if (sco && !sck_d) begin
            per <= cnt;
            cnt <= 1;
        end else cnt <= cnt + 1;
        if (!sel_n) sel_lo <= sel_lo + 1;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // slave word in mode 3, msb first, link period of 8 mclk
    task automatic slv_byte(input logic [7:0] b);
        ssel_n <= 1'b0;
        slv    <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int k = 7; k >= 0; k--) begin
            ssck <= 1'b0;
            sbit <= b[k];
            repeat (4) @(posedge mclk);
            ssck <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
        ssel_n <= 1'b1;
    endtask
    task automatic wait_done();
        logic [31:0] st;
        for (int k = 0; k < 300; k++) begin
            rd_reg(`SPCR_OFF_STAT, st);
            if (st[2] === 1'b1) return;
        end
        err_total++;
        $display("CHECK FAILED done flag expected 1 seen 0");
        results();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("select idle", 32'h1, {31'h0, sel_n});
        rd_reg(`SPCR_OFF_CTL, rv);
        chk("ctl reset", 32'h0000_00D0, rv);
        rd_reg(`SPCR_OFF_DIV, rv);
        chk("div reset", 32'h0000_0000, rv);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("stat reset", 32'h0000_0240, rv & 32'h0000_03FD);
        rd_reg(5'h14, rv);
        chk("unmapped", 32'h0000_0000, rv);
        wr_reg(`SPCR_OFF_DIV, 32'hFFFF_FFFF);
        rd_reg(`SPCR_OFF_DIV, rv);
        chk("div width", 32'h0000_03FF, rv);
        wr_reg(`SPCR_OFF_DIV, 32'h0000_0004);
        // slave role: no link activity while the fifo is stuffed
        wr_reg(`SPCR_OFF_CTL, 32'hFFFF_FFFF);
        rd_reg(`SPCR_OFF_CTL, rv);
        chk("ctl mask", 32'h0000_F7FF, rv);
        chk("dma req", 32'h2, {30'h0, tx_drq, rx_drq});
        chk("tx irq", 32'h1, {31'h0, tx_irq});
        for (i = 0; i < 33; i++) wr_reg(`SPCR_OFF_TXD, i);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("tx overflow", 32'h0000_00A0, rv & 32'h0000_02A0);
        wr_reg(`SPCR_OFF_STAT, 32'h0000_0020);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("tx flush", 32'h0000_0200, rv & 32'h0000_02A0);
        @(posedge mclk);
        bus_fault <= 1'b1;
        @(posedge mclk);
        bus_fault <= 1'b0;
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("bus err set", 32'h8, rv & 32'h8);
        wr_reg(`SPCR_OFF_STAT, 32'h0000_0008);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("bus err clr", 32'h0, rv & 32'h8);
        // master words: order, size and reply per table row
        for (i = 0; i < 3; i++) begin
            wr_reg(`SPCR_OFF_CTL, ctl_t[i]);
            repeat (2) @(posedge mclk);
            chk("select low", 32'h0, {31'h0, sel_n});
            chk("sdo drive", 32'h0, {31'h0, oe_n});
            wr_reg(`SPCR_OFF_TXD, tx_t[i]);
            wait_done();
            chk("sck period", 32'd8, per);
            chk("peer word", pe_t[i], got & pm_t[i]);
            rd_reg(`SPCR_OFF_STAT, rv);
            chk("rx pending", 32'h5, rv & 32'h5);
            chk("rx irq", 32'h1, {31'h0, rx_irq});
            wr_reg(`SPCR_OFF_STAT, 32'h0000_0004);
            rd_reg(`SPCR_OFF_STAT, rv);
            chk("done clr", 32'h0, rv & 32'h4);
            rd_reg(`SPCR_OFF_RXD, rv);
            chk("rx word", re_t[i], rv);
            rd_reg(`SPCR_OFF_STAT, rv);
            chk("rx empty", 32'h40, rv & 32'h40);
        end
        wr_reg(`SPCR_OFF_CTL, 32'h0000_80C0);
        wait_done();
        rd_reg(`SPCR_OFF_CTL, rv);
        chk("read start", 32'h0000_00C0, rv);
        wr_reg(`SPCR_OFF_STAT, 32'h0000_0004);
        // mode 0 with level high: only auto select can pull select low
        wr_reg(`SPCR_OFF_CTL, 32'h0000_4010);
        repeat (2) @(posedge mclk);
        chk("select high", 32'h1, {31'h0, sel_n});
        s = sel_lo;
        wr_reg(`SPCR_OFF_TXD, 32'h0000_0055);
        wait_done();
        chk("auto select", 32'h1, {31'h0, sel_lo > s});
        chk("select released", 32'h1, {31'h0, sel_n});
        // 33 more words overrun the 32-deep receive fifo
        for (i = 0; i < 33; i++) wr_reg(`SPCR_OFF_TXD, i);
        repeat (2700) @(posedge mclk);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("rx overflow", 32'h0000_0110, rv & 32'h0000_0110);
        wr_reg(`SPCR_OFF_STAT, 32'h0000_0014);
        rd_reg(`SPCR_OFF_STAT, rv);
        chk("rx flush", 32'h0000_0040, rv & 32'h0000_0154);
        // slave role: the bench drives the link clock
        wr_reg(`SPCR_OFF_CTL, 32'h0000_04C0);
        slv_byte(8'hC3);
        wait_done();
        rd_reg(`SPCR_OFF_RXD, rv);
        chk("slave word", 32'h0000_00C3, rv);
        results();
    end
endmodule // tb_top
